// File: rtl/sccd_top.sv
// Added by the designer: the address map and the APB interface to the registers.
module sccd_top import sccd_pkg::*; #(
  parameter int POWERON_DELAY_TIMER_BASE_CYC = POWERON_DELAY_TIMER_MIN_CYC,
  parameter int HOLD_CYC      = REG_HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire sccd_cfg_s   cfg_i,
  input  wire logic        osc_ready_i,
  input  wire logic        pll_lock_i,
  input  wire logic        osc_fail_i,
  input  wire logic        power_resume_i,
  input  wire logic        low_power_internal_rc_clk_i,
  output logic             exec_enable,
  output logic [2:0]       cur_osc_source,
  output logic             fscm_enable,
  output logic [3:0]       primary_osc_onehot,
  output logic             second_oscillator_pin_o,
  output logic             second_oscillator_pin_oe,
  output logic             low_power_internal_rc_enable,
  output logic             wdt_running,
  output logic             wdt_reset,
  output logic [2:0]       debug_pair_sel,
  output logic             debug_sel_reserved
);
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT_READY, CS_WAIT_LOCK} sccd_cs_e;
  localparam int NSYNC = 5;
  // ==========================================================
  // synchronisers for asynchronous inputs
  wire  [NSYNC-1:0] async_in = {low_power_internal_rc_clk_i, power_resume_i, osc_fail_i, pll_lock_i, osc_ready_i};
  logic [NSYNC-1:0] sync1_q, sync2_q;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire ready_s = sync2_q[0];
  wire lock_s  = sync2_q[1];
  wire fail_s  = sync2_q[2];
  logic low_power_internal_rc_d1_q, resume_d1_q, resumed_q;
  wire low_power_internal_rc_tick  = sync2_q[4] && !low_power_internal_rc_d1_q;
  wire resume_rise = sync2_q[3] && !resume_d1_q;
  // ==========================================================
  // configuration latch, taken at first edge after reset release
  sccd_cfg_s cfg_q;
  logic      loaded_q;
  wire       load = !loaded_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q    <= 1'b0;
      low_power_internal_rc_d1_q   <= 1'b0;
      resume_d1_q <= 1'b0;
      resumed_q   <= 1'b0;
    end else begin
      loaded_q    <= 1'b1;
      low_power_internal_rc_d1_q   <= sync2_q[4];
      resume_d1_q <= sync2_q[3];
      resumed_q   <= resumed_q || resume_rise; // later holds skip the power-on delay
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= '0;
    else if (load) cfg_q <= cfg_i;
  end
  // ==========================================================
  // field decode
  wire sw_enable   = !cfg_q.clock_switch_monitor_mode[1];
  wire mon_enable  = (cfg_q.clock_switch_monitor_mode == 2'h0);
  wire crystal     = (cfg_q.primary_osc_mode == POSC_XT) ||
                     (cfg_q.primary_osc_mode == POSC_HS);
  wire [31:0] por_cyc = (cfg_q.poweron_timer_select == 3'h0) ? 32'h0 :
      (32'(POWERON_DELAY_TIMER_BASE_CYC) << (cfg_q.poweron_timer_select - 3'h1));
  logic        soft_en_q, flag_q, fail_flag_q;
  wire wdt_en      = cfg_q.watchdog_fuse_enable || soft_en_q;
  // ==========================================================
  // APB slave: access phase answered on its second cycle
  logic [2:0]  nosc_q;
  wire         access  = psel && penable && !pready;
  wire         commit  = psel && penable && pready;
  wire         wr      = commit && pwrite && !pslverr;
  wire         hit     = (paddr == REG_CFG) || (paddr == REG_CTRL) ||
                         (paddr == REG_STATUS) || (paddr == REG_WDTCNT);
  wire         wr_ctrl = wr && (paddr == REG_CTRL);
  wire         sw_req  = wr_ctrl && pwdata[CTRL_SW_REQ];
  wire         wdt_clr = wr_ctrl && pwdata[CTRL_WDT_CLR];
  // a switch request may carry its own target in the same write
  wire [2:0]   nosc_d  = wr_ctrl ? pwdata[CTRL_NOSC_LSB +: 3] : nosc_q;
  logic [22:0] wdt_cnt;
  logic        wdt_rst;
  sccd_cs_e    cs_q;
  wire [31:0] status_w = {23'h0, flag_q, fail_flag_q, exec_enable, low_power_internal_rc_enable,
                          wdt_running, (cs_q != CS_IDLE), cur_osc_source};
  wire [31:0] rd_mux =
      (paddr == REG_CFG)    ? 32'(cfg_q) :
      (paddr == REG_CTRL)   ? {25'h0, nosc_q, 3'h0, soft_en_q} :
      (paddr == REG_STATUS) ? status_w :
      (paddr == REG_WDTCNT) ? {9'h0, wdt_cnt} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access;
      pslverr <= access && !hit;
      prdata  <= (access && !pwrite) ? rd_mux : 32'h0;
    end
  end
  // control register; fuse makes the software enable ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_en_q <= 1'b0;
      nosc_q    <= CTRL_NOSC_RST;
    end else if (wr_ctrl) begin
      if (!cfg_q.watchdog_fuse_enable) soft_en_q <= pwdata[CTRL_SOFT_EN];
      nosc_q <= pwdata[CTRL_NOSC_LSB +: 3];
    end
  end
  // sticky watchdog reset flag; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= 1'b0;
    else if (wdt_rst) flag_q <= 1'b1;
    else if (wr_ctrl && pwdata[CTRL_FLAG_CLR]) flag_q <= 1'b0;
  end
  // ==========================================================
  // oscillator switching and fail-safe monitor
  logic [2:0] tgt_q;
  logic       sw_done_q;
  wire tgt_pll  = (tgt_q == OSC_PRI_PLL) || (tgt_q == OSC_FRC_PLL);
  wire req_ok   = sw_enable && (nosc_d != OSC_RSVD) && (nosc_d != cur_osc_source);
  wire fail_sw  = mon_enable && fail_s && (cur_osc_source != OSC_FRC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q           <= CS_IDLE;
      cur_osc_source <= OSC_FRC;
      tgt_q          <= OSC_FRC;
      sw_done_q      <= 1'b0;
      fail_flag_q    <= 1'b0;
    end else begin
      sw_done_q <= 1'b0;
      if (load) begin
        tgt_q <= cfg_i.initial_osc_source;
        if (cfg_i.two_speed_start_sel && cfg_i.initial_osc_source != OSC_FRC) begin
          cur_osc_source <= OSC_FRC;
          cs_q           <= CS_WAIT_READY;
        end else begin
          cur_osc_source <= cfg_i.initial_osc_source;
        end
      end else if (fail_sw) begin
        cur_osc_source <= OSC_FRC;
        cs_q           <= CS_IDLE;
        fail_flag_q    <= 1'b1;
        sw_done_q      <= 1'b1;
      end else begin
        unique case (cs_q)
          CS_IDLE: if (sw_req && req_ok) begin
            tgt_q <= nosc_d;
            cs_q  <= CS_WAIT_READY;
          end
          CS_WAIT_READY: if (ready_s) begin
            if (tgt_pll && cfg_q.pll_lock_wait) cs_q <= CS_WAIT_LOCK;
            else begin
              cur_osc_source <= tgt_q;
              cs_q           <= CS_IDLE;
              sw_done_q      <= 1'b1;
            end
          end
          CS_WAIT_LOCK: if (lock_s) begin
            cur_osc_source <= tgt_q;
            cs_q           <= CS_IDLE;
            sw_done_q      <= 1'b1;
          end
          default: cs_q <= CS_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // pin functions and decoded outputs
  logic clkdiv_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_q                 <= 1'b0;
      second_oscillator_pin_o  <= 1'b0;
      second_oscillator_pin_oe <= 1'b0;
      fscm_enable              <= 1'b0;
      primary_osc_onehot       <= 4'h0;
      low_power_internal_rc_enable              <= 1'b0;
      wdt_running              <= 1'b0;
      debug_pair_sel           <= 3'h0;
      debug_sel_reserved       <= 1'b0;
    end else begin
      clkdiv_q                 <= !clkdiv_q;
      second_oscillator_pin_o  <= clkdiv_q && !crystal;
      second_oscillator_pin_oe <= loaded_q && !crystal && cfg_q.osc_out_pin_function;
      fscm_enable              <= loaded_q && mon_enable;
      primary_osc_onehot       <= loaded_q ? 4'(4'h1 << cfg_q.primary_osc_mode) : 4'h0;
      low_power_internal_rc_enable              <= loaded_q && wdt_en;
      wdt_running              <= loaded_q && wdt_en;
      debug_pair_sel           <= {cfg_q.debug_channel_select == 2'h1,
                                   cfg_q.debug_channel_select == 2'h2,
                                   cfg_q.debug_channel_select == 2'h3};
      debug_sel_reserved       <= loaded_q && (cfg_q.debug_channel_select == 2'h0);
    end
  end
  // ==========================================================
  // submodules
  sccd_startup_timer #(.HOLD_CYC(HOLD_CYC)) u_startup (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (load || resume_rise),
    .por_cycles ((resume_rise || resumed_q) ? 32'h0 : por_cyc),
    .done_q     (exec_enable)
  );
  sccd_watchdog u_wdt (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (wdt_running),
    .tick        (low_power_internal_rc_tick),
    .clear       (wdt_clr),
    .restart     (sw_done_q || load),
    .pre_sel     (cfg_q.watchdog_prescale_sel),
    .post_sel    (cfg_q.watchdog_postscale_sel),
    .window_mode (!cfg_q.watchdog_window_disable),
    .reset_q     (wdt_rst),
    .count_q     (wdt_cnt)
  );
  assign wdt_reset = wdt_rst;
  // ==========================================================
  // checks
  a_cfg_stable: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q |=> $stable(cfg_q)) else $error("configuration changed");
  a_two_speed: assert property (@(posedge pclk) disable iff (!presetn)
    (load && cfg_i.two_speed_start_sel) |=> cur_osc_source == OSC_FRC)
    else $error("two-speed start not on FAST_INTERNAL_RC");
  a_direct_start: assert property (@(posedge pclk) disable iff (!presetn)
    (load && !cfg_i.two_speed_start_sel) |=> cur_osc_source == $past(cfg_i.initial_osc_source))
    else $error("direct start source wrong");
  a_fuse_wdt_on: assert property (@(posedge pclk) disable iff (!presetn)
    (loaded_q && cfg_q.watchdog_fuse_enable) |=> wdt_running && low_power_internal_rc_enable)
    else $error("fuse did not force watchdog");
  a_soft_wdt_off: assert property (@(posedge pclk) disable iff (!presetn)
    (loaded_q && !cfg_q.watchdog_fuse_enable && !soft_en_q) |=> !low_power_internal_rc_enable)
    else $error("LOW_POWER_INTERNAL_RC on with watchdog off");
  a_pll_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cs_q == CS_WAIT_LOCK && !lock_s && !fail_sw) |=> $stable(cur_osc_source))
    else $error("PLL switch before lock");
  a_crystal_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (loaded_q && crystal) |=> !second_oscillator_pin_oe)
    else $error("pin driven in crystal mode");
  a_no_switch: assert property (@(posedge pclk) disable iff (!presetn)
    (cs_q == CS_IDLE && !sw_enable && !load) |=> cs_q == CS_IDLE)
    else $error("switch while switching disabled");
  a_debug_pair: assert property (@(posedge pclk) disable iff (!presetn)
    (loaded_q && cfg_q.debug_channel_select == 2'h3) |=> debug_pair_sel == 3'h1)
    else $error("debug pair 1 not selected");
  c_two_speed_done: cover property (@(posedge pclk) disable iff (!presetn)
    cs_q == CS_WAIT_READY ##[1:50] sw_done_q);
  c_fail_safe: cover property (@(posedge pclk) disable iff (!presetn) fail_sw);
  c_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn) wdt_rst);
  c_exec_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(exec_enable));
endmodule

// File: rtl/sccd_pkg.sv
package sccd_pkg;
  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int REG_HOLD_US    = 20;
  localparam int REG_HOLD_CYC   = REG_HOLD_US * CLK_MHZ;
  localparam int POWERON_DELAY_TIMER_MIN_MS    = 2;
  localparam int POWERON_DELAY_TIMER_MIN_CYC   = POWERON_DELAY_TIMER_MIN_MS * 1000 * CLK_MHZ;
  // ==========================================================
  // register offsets and fields
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WDTCNT = 8'h0C;
  localparam int CTRL_SOFT_EN   = 0;
  localparam int CTRL_SW_REQ    = 1;
  localparam int CTRL_WDT_CLR   = 2;
  localparam int CTRL_FLAG_CLR  = 3;
  localparam int CTRL_NOSC_LSB  = 4;
  localparam logic [2:0] CTRL_NOSC_RST = 3'h0;
  // ==========================================================
  // oscillator source codes
  localparam logic [2:0] OSC_FRC_DIV = 3'h7;
  localparam logic [2:0] OSC_RSVD    = 3'h6;
  localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC    = 3'h5;
  localparam logic [2:0] OSC_SOSC    = 3'h4;
  localparam logic [2:0] OSC_PRI_PLL = 3'h3;
  localparam logic [2:0] OSC_PRI     = 3'h2;
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_FRC     = 3'h0;
  // primary oscillator modes
  localparam logic [1:0] POSC_OFF = 2'h3;
  localparam logic [1:0] POSC_HS  = 2'h2;
  localparam logic [1:0] POSC_XT  = 2'h1;
  localparam logic [1:0] POSC_EXT = 2'h0;
  // watchdog prescale ratios
  localparam logic [7:0] WDT_PRE_LONG  = 8'h80;
  localparam logic [7:0] WDT_PRE_SHORT = 8'h20;
  // ==========================================================
  // nonvolatile configuration word
  typedef struct packed {
    logic       two_speed_start_sel;
    logic [2:0] initial_osc_source;
    logic [1:0] clock_switch_monitor_mode;
    logic       osc_out_pin_function;
    logic [1:0] primary_osc_mode;
    logic       watchdog_fuse_enable;
    logic       watchdog_window_disable;
    logic       pll_lock_wait;
    logic       watchdog_prescale_sel;
    logic [3:0] watchdog_postscale_sel;
    logic [2:0] poweron_timer_select;
    logic [1:0] debug_channel_select;
  } sccd_cfg_s;
  localparam int CFG_W = $bits(sccd_cfg_s);
endpackage

// File: rtl/sccd_startup_timer.sv
// regulator hold, then optional power-on delay, then execution allowed
module sccd_startup_timer import sccd_pkg::*; #(
  parameter int HOLD_CYC = REG_HOLD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [31:0] por_cycles,
  output logic             done_q
);
  typedef enum logic [1:0] {ST_HOLD, ST_POR, ST_DONE} sccd_st_e;
  sccd_st_e    st_q;
  logic [31:0] cnt_q;
  wire hold_end = (cnt_q == 32'(HOLD_CYC - 1));
  wire por_end  = (cnt_q >= por_cycles - 32'h1) || (por_cycles == 32'h0);
  // ==========================================================
  // sequence; any start restarts the regulator hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_HOLD;
      cnt_q  <= 32'h0;
      done_q <= 1'b0;
    end else if (start) begin
      st_q   <= ST_HOLD;
      cnt_q  <= 32'h0;
      done_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_HOLD: begin
          cnt_q <= hold_end ? 32'h0 : cnt_q + 32'h1;
          if (hold_end) st_q <= ST_POR;
        end
        ST_POR: begin
          cnt_q <= cnt_q + 32'h1;
          if (por_end) begin
            st_q   <= ST_DONE;
            done_q <= 1'b1;
          end
        end
        ST_DONE: done_q <= 1'b1;
        default: st_q <= ST_HOLD; // unused code falls back to the hold
      endcase
    end
  end
  // ==========================================================
  // checks
  a_hold_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> !done_q [*8]) else $error("execution not held after start");
  a_hold_length: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOLD && !start) |-> !done_q) else $error("done during hold");
endmodule

// File: rtl/sccd_watchdog.sv
// watchdog counter: prescale x postscale ticks, optional clear window
module sccd_watchdog import sccd_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enable,
  input  wire logic        tick,
  input  wire logic        clear,
  input  wire logic        restart,
  input  wire logic        pre_sel,
  input  wire logic [3:0]  post_sel,
  input  wire logic        window_mode,
  output logic             reset_q,
  output logic [22:0]      count_q
);
  wire [7:0]  pre_div  = pre_sel ? WDT_PRE_LONG : WDT_PRE_SHORT;
  wire [22:0] period   = 23'(pre_div) << post_sel;
  wire [22:0] win_open = period - (period >> 2);
  wire early_clr = enable && clear && window_mode && (count_q < win_open);
  wire timeout   = enable && tick && (count_q == period - 23'h1);
  // ==========================================================
  // count; restart, clear or disable zero it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 23'h0;
      reset_q <= 1'b0;
    end else begin
      reset_q <= early_clr || timeout;
      if (!enable || clear || restart || timeout) count_q <= 23'h0;
      else if (tick) count_q <= count_q + 23'h1;
    end
  end
  // ==========================================================
  // checks
  a_window_early: assert property (@(posedge pclk) disable iff (!presetn)
    early_clr |=> reset_q) else $error("early clear gave no reset");
  a_no_window: assert property (@(posedge pclk) disable iff (!presetn)
    (!window_mode && clear && !timeout) |=> !reset_q) else $error("reset outside window mode");
  a_prescale_pick: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && tick && count_q == (23'(pre_sel ? 8'h80 : 8'h20) << post_sel) - 23'h1
     && !clear && !restart) |=> reset_q && count_q == 23'h0)
    else $error("timeout at wrong count");
endmodule

// File: verification/sccd_top_bench.sv
module sccd_top_bench import sccd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bench signals
  localparam int PB = 20;
  localparam int HC = 10;
  logic        pclk, presetn, psel, penable, pwrite, osc_ready_i, pll_lock_i;
  logic        osc_fail_i, power_resume_i, low_power_internal_rc_clk_i, pready, pslverr, er;
  logic        exec_enable, fscm_enable, pin_o, pin_oe, low_power_internal_rc_enable;
  logic        wdt_running, wdt_reset, debug_sel_reserved;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, s;
  logic [2:0]  cur_osc_source, debug_pair_sel;
  logic [3:0]  primary_osc_onehot;
  sccd_cfg_s   cfg_i, c;
  int          error_cnt, tests_run, cnt, rel, np, p0, e;
  sccd_top #(.POWERON_DELAY_TIMER_BASE_CYC(PB), .HOLD_CYC(HC)) u_sccd_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_i(cfg_i), .osc_ready_i(osc_ready_i), .pll_lock_i(pll_lock_i),
    .osc_fail_i(osc_fail_i), .power_resume_i(power_resume_i), .low_power_internal_rc_clk_i(low_power_internal_rc_clk_i),
    .exec_enable(exec_enable), .cur_osc_source(cur_osc_source), .fscm_enable(fscm_enable),
    .primary_osc_onehot(primary_osc_onehot), .second_oscillator_pin_o(pin_o),
    .second_oscillator_pin_oe(pin_oe), .low_power_internal_rc_enable(low_power_internal_rc_enable),
    .wdt_running(wdt_running), .wdt_reset(wdt_reset), .debug_pair_sel(debug_pair_sel),
    .debug_sel_reserved(debug_sel_reserved));
  // ==========================================================
  // clock, cycle counter, watchdog pulse counter
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    if (wdt_reset === 1'b1) np <= np + 1;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic int por(input logic [2:0] t);
    return (t == 3'h0) ? 0 : PB << (t - 3'h1);
  endfunction
  function automatic logic [3:0] dbg(input logic [1:0] t);
    case (t)
      2'h3: return 4'h1;
      2'h2: return 4'h2;
      2'h1: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // apb transfer: hold request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input sccd_cfg_s k);
    @(posedge pclk);
    cfg_i <= k;
    presetn <= 1'b0;
    cyc(4);
    presetn <= 1'b1;
    rel = cnt;
  endtask
  task automatic wexec();
    while (exec_enable !== 1'b1 && cnt - rel < 3000) @(posedge pclk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      low_power_internal_rc_clk_i <= 1'b1;
      cyc(4);
      low_power_internal_rc_clk_i <= 1'b0;
      cyc(4);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, osc_fail_i, power_resume_i, low_power_internal_rc_clk_i} = '0;
    {osc_ready_i, paddr, pwdata, error_cnt, tests_run} = '0;
    cfg_i = '0;
    s = 32'h1B91;
    pll_lock_i = 1'b1;
    // timeout: a hang counts as a mismatch and ends the run
    fork
      begin
        wait (cnt == 60000);
        error_cnt++;
        print_verdict();
      end
    join_none
    // random configurations, with delay extremes forced
    for (int i = 0; i < 12; i++) begin
      rd = rnd();
      c = rd[21:0];
      if (c.initial_osc_source == OSC_RSVD) c.initial_osc_source = OSC_PRI;
      if (i < 2) c.poweron_timer_select = i ? 3'h0 : 3'h7;
      osc_ready_i <= 1'b0;
      rst(c);
      e = HC + por(c.poweron_timer_select);
      wexec();
      chk(cnt - rel >= e - 1 && cnt - rel <= e + 5, 1'b1);
      cfg_i <= ~c;
      cyc(2);
      chk(primary_osc_onehot, 4'h1 << c.primary_osc_mode);
      chk(fscm_enable, c.clock_switch_monitor_mode == 2'h0);
      chk({debug_sel_reserved, debug_pair_sel}, dbg(c.debug_channel_select));
      e = c.primary_osc_mode[1] == c.primary_osc_mode[0];
      chk(pin_oe, e & c.osc_out_pin_function);
      er = pin_o;
      cyc(1);
      chk(pin_o ^ er, e);
      chk(cur_osc_source, c.two_speed_start_sel ? OSC_FRC : c.initial_osc_source);
      osc_ready_i <= 1'b1;
      cyc(6);
      chk(cur_osc_source, c.initial_osc_source);
      apb(1'b0, REG_CFG, 32'h0);
      chk(rd, {10'h0, c});
      apb(1'b1, REG_CTRL, 32'h1);
      cyc(2);
      chk({wdt_running, low_power_internal_rc_enable}, 2'h3);
      apb(1'b1, REG_CTRL, 32'h0);
      cyc(2);
      chk({wdt_running, low_power_internal_rc_enable}, {2{c.watchdog_fuse_enable}});
    end
    // resume after power-down repeats the regulator hold
    rel = cnt;
    power_resume_i <= 1'b1;
    cyc(4);
    chk(exec_enable, 1'b0);
    power_resume_i <= 1'b0;
    wexec();
    chk(cnt - rel >= HC && cnt - rel <= HC + 6, 1'b1);
    // window watchdog, shortest period of 32 ticks
    c = '0;
    c.watchdog_fuse_enable = 1'b1;
    c.clock_switch_monitor_mode = 2'h2;
    rst(c);
    wexec();
    p0 = np;
    tick(25);
    apb(1'b1, REG_CTRL, 32'h4);
    cyc(4);
    chk(np - p0, 0);
    tick(3);
    apb(1'b1, REG_CTRL, 32'h4);
    cyc(4);
    chk(np - p0, 1);
    tick(31);
    chk(np - p0, 1);
    tick(1);
    cyc(4);
    chk(np - p0, 2);
    tick(5);
    apb(1'b0, REG_WDTCNT, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, REG_CTRL, 32'h22);
    cyc(8);
    chk(cur_osc_source, OSC_FRC);
    // non-window mode ignores early clears; long prescale gives 128 ticks
    c.watchdog_window_disable = 1'b1;
    c.watchdog_prescale_sel = 1'b1;
    rst(c);
    wexec();
    p0 = np;
    tick(3);
    apb(1'b1, REG_CTRL, 32'h4);
    cyc(4);
    chk(np - p0, 0);
    tick(127);
    chk(np - p0, 0);
    tick(1);
    cyc(4);
    chk(np - p0, 1);
    // switch to pll source waits for lock
    c.clock_switch_monitor_mode = 2'h1;
    c.pll_lock_wait = 1'b1;
    pll_lock_i <= 1'b0;
    rst(c);
    wexec();
    apb(1'b1, REG_CTRL, 32'h32);
    cyc(10);
    chk(cur_osc_source, OSC_FRC);
    pll_lock_i <= 1'b1;
    cyc(8);
    chk(cur_osc_source, OSC_PRI_PLL);
    // fail-safe monitor drops a failed primary back to fast RC
    c.clock_switch_monitor_mode = 2'h0;
    c.initial_osc_source = OSC_PRI;
    rst(c);
    wexec();
    chk(cur_osc_source, OSC_PRI);
    osc_fail_i <= 1'b1;
    cyc(4);
    chk(cur_osc_source, OSC_FRC);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[7], 1'b1);
    osc_fail_i <= 1'b0;
    // unmapped address is refused
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    print_verdict();
  end
endmodule
